// ---- common/stsc_pkg.sv ----
// Contract
// [R01] one standby enable bit per input
// [R02] standby inputs use standby settings only
// [R03] zero averages samples, one sums them
// [R04] host uses summation with care
// [R05] three-bit code selects power-of-two sample count
// [R06] all samples of one channel consecutively
// [R07] two-bit code sets single sample duration
// [R08] two-bit code sets sensing cycle period
// [R09] sample at cycle start, then low power
// [R10] cycle stretches when sampling runs longer
// [R11] three-bit code selects delta multiplier
// [R12] multiplier scales delta before comparison
// [R13] delta msb is 64 to 8192 counts
// [R14] seven-bit standby threshold, touch when exceeded
// [R15] unused gain bits read zero
package stsc_pkg;

  // register offsets
  localparam logic [7:0] OFS_INPUT_ENABLE = 8'h40;
  localparam logic [7:0] OFS_SAMPLING_SETUP = 8'h41;
  localparam logic [7:0] OFS_GAIN_SELECT = 8'h42;
  localparam logic [7:0] OFS_THRESHOLD = 8'h43;
  localparam logic [7:0] OFS_TOUCH_STATUS = 8'h44;
  localparam logic [7:0] OFS_LAST_DELTA = 8'h45;

  // reset values
  localparam logic [7:0] RST_INPUT_ENABLE = 8'h00;
  localparam logic [7:0] RST_SAMPLING_SETUP = 8'h39;
  localparam logic [7:0] RST_GAIN_SELECT = 8'h02;
  localparam logic [6:0] RST_THRESHOLD = 7'h40;

  // field positions of the sampling setup and gain registers, read masks
  localparam int POS_ACCUMULATE_SELECT = 7;
  localparam int POS_SAMPLE_COUNT = 4;
  localparam int POS_SAMPLE_DURATION = 2;
  localparam int POS_CYCLE_PERIOD = 0;
  localparam int POS_GAIN = 0;
  localparam logic [7:0] GAIN_MASK = 8'h07;
  localparam logic [7:0] THRESHOLD_MASK = 8'h7f;

  // timing: code 0 of each field; higher codes are multiples
  localparam int CLK_MHZ = 250;
  localparam int SAMPLE_TIME_BASE_US = 320;
  localparam int CYCLE_TIME_BASE_MS = 35;
  localparam int SAMPLE_BASE_CYCLES = SAMPLE_TIME_BASE_US * CLK_MHZ;
  localparam int CYCLE_BASE_CYCLES = CYCLE_TIME_BASE_MS * 1000 * CLK_MHZ;

  // widths
  localparam int RAW_W = 16;
  localparam int ACC_W = 24;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_EVAL = 4'h4,
    ST_SLEEP = 4'h8
  } stsc_state_e;

endpackage

// ---- hw/stsc_delta_eval.sv ----
// delta count scaling and threshold compare for one measurement
`timescale 1ns/10ps
module stsc_delta_eval (
  // measurement
  input wire logic signed [stsc_pkg::ACC_W-1:0] acc_i,
  // settings
  input wire logic accumulate_select_i,
  input wire logic [2:0] standby_sample_count_i,
  input wire logic [2:0] standby_gain_i,
  input wire logic [6:0] threshold_i,
  // result
  output logic [7:0] delta_o,
  output logic touch_o
);

  logic signed [stsc_pkg::ACC_W-1:0] combined;
  logic signed [stsc_pkg::ACC_W-1:0] scaled;

  always_comb begin
    // mean is the total shifted by the power-of-two count
    if (accumulate_select_i) begin
      combined = acc_i; // R03
    end else begin
      combined = acc_i >>> standby_sample_count_i; // R03 R05
    end
    // gain code 0 keeps 64 raw counts on bit 6, code 7 needs 8192
    scaled = combined >>> standby_gain_i; // R11 R12 R13
    if (accumulate_select_i) begin
      // totals wrap into the delta count, as a large touch would
      delta_o = scaled[7:0]; // R03
    end else if (scaled > 24'sh00_007f) begin
      delta_o = 8'h7f;
    end else if (scaled < -24'sh00_0080) begin
      delta_o = 8'h80;
    end else begin
      delta_o = scaled[7:0];
    end
    touch_o = $signed(delta_o) > $signed({1'b0, threshold_i}); // R14
  end

endmodule

// ---- hw/stsc_top.sv ----
// standby touch sensing sequencer with its configuration registers
`timescale 1ns/10ps
module stsc_top #(
  parameter int SAMPLE_BASE_CYCLES = stsc_pkg::SAMPLE_BASE_CYCLES,
  parameter int CYCLE_BASE_CYCLES = stsc_pkg::CYCLE_BASE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // power state
  input wire logic standby_i,
  output logic low_power_o,
  // sensor front end
  output logic sample_start_o,
  output logic [2:0] sense_channel_o,
  input wire logic signed [stsc_pkg::RAW_W-1:0] sample_value_i,
  // results
  output logic [7:0] touch_status_o
);

  typedef struct packed {
    logic [7:0] input_enable;
    logic [7:0] sampling_setup;
    logic [2:0] gain;
    logic [6:0] threshold;
    stsc_pkg::stsc_state_e state;
    logic [2:0] chan;
    logic [7:0] samp_cnt;
    logic [31:0] samp_timer;
    logic [31:0] cycle_timer;
    logic signed [stsc_pkg::ACC_W-1:0] acc;
    logic [7:0] touch;
    logic [7:0] last_delta;
    logic [7:0] rdata;
    logic low_power;
    logic sample_start;
  } stsc_regs_s;

  localparam stsc_regs_s REGS_RESET = '{
    input_enable: stsc_pkg::RST_INPUT_ENABLE,
    sampling_setup: stsc_pkg::RST_SAMPLING_SETUP,
    gain: stsc_pkg::RST_GAIN_SELECT[2:0],
    threshold: stsc_pkg::RST_THRESHOLD,
    state: stsc_pkg::ST_IDLE,
    chan: 3'h0,
    samp_cnt: 8'h00,
    samp_timer: 32'h0000_0000,
    cycle_timer: 32'h0000_0000,
    acc: '0,
    touch: 8'h00,
    last_delta: 8'h00,
    rdata: 8'h00,
    low_power: 1'b0,
    sample_start: 1'b0
  };

  stsc_regs_s regs_reg;
  stsc_regs_s regs_next;

  // decoded settings
  logic accumulate_select;
  logic [2:0] standby_sample_count;
  logic [1:0] standby_sample_duration;
  logic [1:0] standby_cycle_period;
  logic [7:0] samples_needed;
  logic [31:0] sample_cycles;
  logic [31:0] cycle_cycles;
  logic [7:0] eval_delta;
  logic eval_touch;

  assign accumulate_select = regs_reg.sampling_setup[stsc_pkg::POS_ACCUMULATE_SELECT];
  assign standby_sample_count = regs_reg.sampling_setup[stsc_pkg::POS_SAMPLE_COUNT +: 3];
  assign standby_sample_duration = regs_reg.sampling_setup[stsc_pkg::POS_SAMPLE_DURATION +: 2];
  assign standby_cycle_period = regs_reg.sampling_setup[stsc_pkg::POS_CYCLE_PERIOD +: 2];
  assign samples_needed = 8'h01 << standby_sample_count; // R05
  assign sample_cycles = 32'(SAMPLE_BASE_CYCLES) << standby_sample_duration; // R07
  assign cycle_cycles = 32'(CYCLE_BASE_CYCLES) * {30'h0000_0000, standby_cycle_period}
    + 32'(CYCLE_BASE_CYCLES); // R08

  // lowest enabled channel at or above start; bit 3 flags a hit
  function automatic logic [3:0] find_enabled(input logic [7:0] en, input logic [3:0] start);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (en[i] && (4'(i) >= start)) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  stsc_delta_eval u_eval (
    .acc_i(regs_reg.acc),
    .accumulate_select_i(accumulate_select),
    .standby_sample_count_i(standby_sample_count),
    .standby_gain_i(regs_reg.gain),
    .threshold_i(regs_reg.threshold),
    .delta_o(eval_delta),
    .touch_o(eval_touch)
  );

  always_comb begin
    logic [3:0] hit;
    hit = 4'h0;
    regs_next = regs_reg;
    regs_next.sample_start = 1'b0;
    regs_next.rdata = 8'h00;

    // register writes
    if (reg_write_i) begin
      case (reg_addr_i)
        stsc_pkg::OFS_INPUT_ENABLE: begin
          regs_next.input_enable = reg_wdata_i; // R01
        end
        stsc_pkg::OFS_SAMPLING_SETUP: begin
          regs_next.sampling_setup = reg_wdata_i;
        end
        stsc_pkg::OFS_GAIN_SELECT: begin
          regs_next.gain = reg_wdata_i[stsc_pkg::POS_GAIN +: 3]; // R15
        end
        stsc_pkg::OFS_THRESHOLD: begin
          regs_next.threshold = reg_wdata_i[6:0]; // R14
        end
        default: begin
        end
      endcase
    end

    // register reads, data in the following cycle only
    if (reg_read_i) begin
      case (reg_addr_i)
        stsc_pkg::OFS_INPUT_ENABLE: begin
          regs_next.rdata = regs_reg.input_enable;
        end
        stsc_pkg::OFS_SAMPLING_SETUP: begin
          regs_next.rdata = regs_reg.sampling_setup;
        end
        stsc_pkg::OFS_GAIN_SELECT: begin
          regs_next.rdata = {5'h00, regs_reg.gain} & stsc_pkg::GAIN_MASK; // R15
        end
        stsc_pkg::OFS_THRESHOLD: begin
          regs_next.rdata = {1'b0, regs_reg.threshold} & stsc_pkg::THRESHOLD_MASK;
        end
        stsc_pkg::OFS_TOUCH_STATUS: begin
          regs_next.rdata = regs_reg.touch;
        end
        stsc_pkg::OFS_LAST_DELTA: begin
          regs_next.rdata = regs_reg.last_delta;
        end
        default: begin
          regs_next.rdata = 8'h00;
        end
      endcase
    end

    // sequencer
    regs_next.cycle_timer = regs_reg.cycle_timer + 32'h0000_0001;
    case (regs_reg.state)
      stsc_pkg::ST_IDLE: begin
        regs_next.low_power = 1'b0;
        // the idle cycle is the first cycle of the new period
        regs_next.cycle_timer = 32'h0000_0001; // R08
        if (standby_i) begin
          // a new cycle opens by sampling every enabled input
          hit = find_enabled(regs_reg.input_enable, 4'h0); // R01 R09
          regs_next.acc = '0;
          regs_next.samp_cnt = 8'h00;
          regs_next.samp_timer = sample_cycles - 32'h0000_0001;
          if (hit[3]) begin
            regs_next.chan = hit[2:0];
            regs_next.state = stsc_pkg::ST_SAMPLE;
            regs_next.sample_start = 1'b1;
          end else begin
            regs_next.state = stsc_pkg::ST_SLEEP;
            regs_next.low_power = 1'b1;
          end
        end
      end
      stsc_pkg::ST_SAMPLE: begin
        if (regs_reg.samp_timer != 32'h0000_0000) begin
          regs_next.samp_timer = regs_reg.samp_timer - 32'h0000_0001; // R07
        end else begin
          regs_next.acc = regs_reg.acc + stsc_pkg::ACC_W'(sample_value_i);
          regs_next.samp_cnt = regs_reg.samp_cnt + 8'h01;
          if (regs_reg.samp_cnt + 8'h01 == samples_needed) begin
            regs_next.state = stsc_pkg::ST_EVAL; // R06
          end else begin
            // next sample stays on the same channel
            regs_next.samp_timer = sample_cycles - 32'h0000_0001; // R06
            regs_next.sample_start = 1'b1;
          end
        end
      end
      stsc_pkg::ST_EVAL: begin
        // standby threshold, count, gain and accumulate select only
        regs_next.last_delta = eval_delta; // R02 R12
        regs_next.touch[regs_reg.chan] = eval_touch; // R02 R14
        regs_next.acc = '0;
        regs_next.samp_cnt = 8'h00;
        regs_next.samp_timer = sample_cycles - 32'h0000_0001;
        hit = find_enabled(regs_reg.input_enable, {1'b0, regs_reg.chan} + 4'h1);
        if (hit[3]) begin
          regs_next.chan = hit[2:0];
          regs_next.state = stsc_pkg::ST_SAMPLE;
          regs_next.sample_start = 1'b1;
        end else begin
          regs_next.state = stsc_pkg::ST_SLEEP; // R09
          regs_next.low_power = 1'b1;
        end
      end
      stsc_pkg::ST_SLEEP: begin
        // an overrun cycle ends at once, so sampling stretches it
        if (regs_reg.cycle_timer >= cycle_cycles - 32'h0000_0001) begin // R10
          regs_next.low_power = 1'b0;
          regs_next.state = stsc_pkg::ST_IDLE; // R09
        end
      end
      default: begin
        regs_next.state = stsc_pkg::ST_IDLE;
        regs_next.low_power = 1'b0;
      end
    endcase

    // leaving standby aborts the cycle
    if (!standby_i) begin
      regs_next.state = stsc_pkg::ST_IDLE;
      regs_next.low_power = 1'b0;
      regs_next.sample_start = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      regs_reg <= REGS_RESET;
    end else begin
      regs_reg <= regs_next;
    end
  end

  assign reg_rdata_o = regs_reg.rdata;
  assign low_power_o = regs_reg.low_power;
  assign sample_start_o = regs_reg.sample_start;
  assign sense_channel_o = regs_reg.chan;
  assign touch_status_o = regs_reg.touch;

endmodule

// ---- test/stsc_checker.sv ----
// port assertions for the standby sensing block
`timescale 1ns/10ps
module stsc_checker #(
  parameter int SAMPLE_BASE_CYCLES = 4,
  parameter int CYCLE_BASE_CYCLES = 200
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  // sequencing
  input wire logic standby_i,
  input wire logic low_power_o,
  input wire logic sample_start_o,
  input wire logic [2:0] sense_channel_o
);
  logic [7:0] en_reg;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      en_reg <= 8'h00;
    end else if (reg_write_i && reg_addr_i == 8'h40) begin
      en_reg <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // window is at least four cycles in this bench
  sequence s_window;
    !sample_start_o [*3];
  endsequence
  sequence s_restart;
    ##[0:4] (sample_start_o || !standby_i);
  endsequence
  a_gain_clean: assert property (reg_read_i && reg_addr_i == 8'h42 |=> reg_rdata_o[7:3] == 5'h00)
    else $error("gain register upper bits not zero");
  a_thr_clean: assert property (reg_read_i && reg_addr_i == 8'h43 |=> !reg_rdata_o[7])
    else $error("threshold bit 7 not zero");
  a_rd_enable: assert property (reg_read_i && reg_addr_i == 8'h40 |=> reg_rdata_o == en_reg)
    else $error("enable register readback wrong");
  a_window_len: assert property (sample_start_o |=> s_window)
    else $error("sample windows too close");
  a_sleep_quiet: assert property (low_power_o |-> !sample_start_o)
    else $error("sample started in low power");
  a_enabled_only: assert property (sample_start_o |-> en_reg[sense_channel_o])
    else $error("disabled input sampled");
  a_abort_stop: assert property (!standby_i |=> !sample_start_o)
    else $error("sampling outside standby");
  a_lp_exit: assert property ($fell(low_power_o) && standby_i && en_reg != 8'h00 |-> s_restart)
    else $error("no new cycle after low power");
endmodule
bind stsc_top stsc_checker #(.SAMPLE_BASE_CYCLES(SAMPLE_BASE_CYCLES), .CYCLE_BASE_CYCLES(CYCLE_BASE_CYCLES)) u_stsc_checker (
  .sys_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .standby_i,
  .low_power_o, .sample_start_o, .sense_channel_o);

// ---- test/stsc_pad_model.sv ----
// sensor pad model: raw delta of the selected input
`timescale 1ns/10ps
module stsc_pad_model (
  // selection
  input wire logic [2:0] sense_channel_i,
  // raw delta
  output logic signed [stsc_pkg::RAW_W-1:0] sample_value_o
);
  logic signed [stsc_pkg::RAW_W-1:0] level [8];
  assign sample_value_o = level[sense_channel_i];
endmodule

// ---- test/stsc_tb_top.sv ----
// testbench for the standby sensing block
`timescale 1ns/10ps
module stsc_tb_top;
  logic sys_clk_i, reset_i, reg_write_i, reg_read_i, standby_i, low_power_o, sample_start_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, touch_status_o;
  logic [2:0] sense_channel_o;
  logic signed [stsc_pkg::RAW_W-1:0] sample_value_i;
  int n_errors = 0, cmp_count = 0, cyc = 0, lp_cnt = 0, per;
  int q_t[$];
  logic [2:0] q_ch[$];
  stsc_top #(.SAMPLE_BASE_CYCLES(4), .CYCLE_BASE_CYCLES(200)) u_stsc_top (.sys_clk_i, .reset_i, .reg_addr_i,
    .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .standby_i, .low_power_o, .sample_start_o,
    .sense_channel_o, .sample_value_i, .touch_status_o);
  stsc_pad_model u_stsc_pad_model (.sense_channel_i(sense_channel_o), .sample_value_o(sample_value_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (sample_start_o === 1'b1) begin
      q_t.push_back(cyc);
      q_ch.push_back(sense_channel_o);
    end
    if (low_power_o === 1'b1) lp_cnt++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_read_i <= 1'b0;
    #1 check(reg_rdata_o, exp);
    @(posedge sys_clk_i);
  endtask
  task automatic t_defaults();
    rdc(8'h40, 8'h00);
    rdc(8'h41, 8'h39);
    rdc(8'h42, 8'h02);
    rdc(8'h43, 8'h40);
  endtask
  task automatic t_access();
    wr(8'h42, 8'hff);
    rdc(8'h42, 8'h07);
    wr(8'h43, 8'hff);
    rdc(8'h43, 8'h7f);
    wr(8'h44, 8'hff);
    rdc(8'h44, 8'h00);
    wr(8'h50, 8'haa);
    rdc(8'h50, 8'h00);
    wr(8'h40, 8'ha5);
    rdc(8'h40, 8'ha5);
  endtask
  // inputs 0 and 2 enabled; cycle length returned
  task automatic t_sense(input logic [7:0] setup, gain, thr, exp, input int w, n, s, output int p);
    wr(8'h40, 8'h05);
    wr(8'h41, setup);
    wr(8'h42, gain);
    wr(8'h43, thr);
    q_t.delete();
    q_ch.delete();
    lp_cnt = 0;
    standby_i <= 1'b1;
    repeat (w) @(posedge sys_clk_i);
    check(touch_status_o, exp);
    check(q_ch[0], 3'h0);
    check(q_ch[n - 1], 3'h0);
    check(q_ch[n], 3'h2);
    check(32'(q_t[1] - q_t[0]), 32'(s));
    check(32'(lp_cnt > 0 || n > 64), 1);
    p = q_t[2 * n] - q_t[0];
    standby_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
  endtask
  initial begin
    reset_i = 1'b1;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    standby_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    for (int i = 0; i < 8; i++) u_stsc_pad_model.level[i] = 16'sh0000;
    u_stsc_pad_model.level[0] = 16'sh000a;
    u_stsc_pad_model.level[2] = 16'sh0003;
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    t_defaults();
    t_access();
    t_sense(8'h10, 8'h00, 8'h05, 8'h01, 300, 2, 4, per);
    check(per, 200);
    // small deltas keep the sum clear of overflow
    t_sense(8'h90, 8'h00, 8'h05, 8'h05, 300, 2, 4, per);
    t_sense(8'h15, 8'h01, 8'h05, 8'h00, 450, 2, 8, per);
    check(per, 400);
    t_sense(8'h70, 8'h00, 8'h05, 8'h01, 1200, 128, 4, per);
    check(32'(per > 1024 && per < 1040), 1);
    rdc(8'h45, 8'h03);
    u_stsc_pad_model.level[0] <= 16'sh2000;
    u_stsc_pad_model.level[2] <= 16'sh1fff;
    t_sense(8'h10, 8'h07, 8'h3f, 8'h01, 300, 2, 4, per);
    rdc(8'h45, 8'h3f);
    t_sense(8'h10, 8'h06, 8'h3f, 8'h05, 300, 2, 4, per);
    rdc(8'h45, 8'h7f);
    check(per, 200);
    // a large summed touch wraps the delta count
    t_sense(8'h90, 8'h06, 8'h3f, 8'h00, 300, 2, 4, per);
    rdc(8'h45, 8'hff);
    results();
  end
  task automatic results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule
